/* hdl/slb_pkg.sv */
// Purpose: Shared constants for the synthesizer latch bank.
// Assumes: 24-bit serial words, selector in the two lowest bits.
// Notes: Bit positions are those of the three programmed latches.
package slb_pkg;
   localparam int WORD_W = 24;
   localparam logic [1:0] SEL_CONTROL = 2'h0;
   localparam logic [1:0] SEL_REFERENCE = 2'h1;
   localparam logic [1:0] SEL_FEEDBACK = 2'h2;
   localparam logic [1:0] SEL_TEST = 2'h3;
   // Control word fields.
   localparam int CT_PRESCALE_HI = 23;
   localparam int CT_PRESCALE_LO = 22;
   localparam int CT_PD_SYNC = 21;
   localparam int CT_PD_REQ = 20;
   localparam int CT_CUR2_HI = 19;
   localparam int CT_CUR2_LO = 17;
   localparam int CT_CUR1_HI = 16;
   localparam int CT_CUR1_LO = 14;
   localparam int CT_DRIVE_HI = 13;
   localparam int CT_DRIVE_LO = 12;
   localparam int CT_MUTE = 11;
   localparam int CT_GAIN = 10;
   localparam int CT_TRISTATE = 9;
   localparam int CT_POLARITY = 8;
   localparam int CT_MON_HI = 7;
   localparam int CT_MON_LO = 5;
   localparam int CT_CLEAR = 4;
   localparam int CT_BIAS_HI = 3;
   localparam int CT_BIAS_LO = 2;
   // Feedback word fields.
   localparam int FB_HALVE_SEL = 23;
   localparam int FB_HALVE = 22;
   localparam int FB_GAIN = 21;
   localparam int FB_MAIN_HI = 20;
   localparam int FB_MAIN_LO = 8;
   localparam int FB_SPARE = 7;
   localparam int FB_SWALLOW_HI = 6;
   localparam int FB_SWALLOW_LO = 2;
   // Reference word fields.
   localparam int RF_SPARE_HI = 23;
   localparam int RF_SPARE_LO = 22;
   localparam int RF_BAND_HI = 21;
   localparam int RF_BAND_LO = 20;
   localparam int RF_TEST = 19;
   localparam int RF_PRECISION = 18;
   localparam int RF_ABL_HI = 17;
   localparam int RF_ABL_LO = 16;
   localparam int RF_COUNT_HI = 15;
   localparam int RF_COUNT_LO = 2;
   // Reset values and counts.
   localparam logic [23:0] WORD_RESET = 24'h000000;
   localparam int BAND_CYCLES = 5;
   localparam int SYNC_PD_EDGES = 2;
   typedef enum logic [1:0] {SLB_OFF, SLB_ON, SLB_PD_WAIT} slb_power_t;
endpackage

/* hdl/slb_serial_if.sv */
// Purpose: Carries a completed serial word to the latch bank.
// Assumes: One clk_sys domain.
// Notes: word_valid is a one-cycle pulse at the load strobe rise.
interface slb_serial_if;
   logic [23:0] word;
   logic word_valid;
   modport shifter (output word, output word_valid);
   modport bank (input word, input word_valid);
endinterface

/* hdl/slb_shifter.sv */
// Purpose: Three-wire input shift register, sampled in clk_sys.
// Assumes: Serial pins already synchronised by the caller.
// Notes: Keeps shifting in every power state.
module slb_shifter
   import slb_pkg::*;
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic sclk_sync,
   input wire logic sdata_sync,
   input wire logic strobe_sync,
   slb_serial_if.shifter sif
);
   logic sclk_d;
   logic strobe_d;
   logic [23:0] shift;

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         sclk_d <= 1'b0;
         strobe_d <= 1'b0;
      end else begin
         sclk_d <= sclk_sync;
         strobe_d <= strobe_sync;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         shift <= WORD_RESET;
      end else if (sclk_sync && !sclk_d) begin
         shift <= {shift[22:0], sdata_sync};
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         sif.word <= WORD_RESET;
         sif.word_valid <= 1'b0;
      end else begin
         sif.word_valid <= strobe_sync && !strobe_d;
         if (strobe_sync && !strobe_d) begin
            sif.word <= shift;
         end
      end
   end
endmodule

/* hdl/slb_latch_bank.sv */
// Purpose: Configuration latch bank and power-down control of a synthesizer.
// Assumes: Pins and lock/reference inputs arrive asynchronously.
// Notes: Fields without reproduced encodings are passed through raw.
module slb_latch_bank
   import slb_pkg::*;
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic serial_clk,
   input wire logic serial_data,
   input wire logic load_strobe,
   input wire logic chip_enable,
   input wire logic ref_div_out,
   input wire logic loop_locked,
   output logic powered,
   output logic bias_settle_start,
   output logic counters_load,
   output logic pump_tristate_out,
   output logic lock_detect_reset,
   output logic rf_output_enable,
   output logic ref_buffer_enable,
   output logic band_select_busy,
   output logic [2:0] pump_current,
   output logic [1:0] prescale_sel,
   output logic [1:0] output_drive,
   output logic [1:0] core_bias_level,
   output logic [2:0] monitor_select,
   output logic detector_polarity,
   output logic counter_clear,
   output logic feedback_halve_select,
   output logic output_halve,
   output logic [12:0] main_count,
   output logic [4:0] swallow_count,
   output logic [1:0] band_clock_div,
   output logic factory_test_bit,
   output logic lock_precision,
   output logic [1:0] antibacklash_width,
   output logic [13:0] ref_count
);
   logic [4:0] meta;
   logic [4:0] sync;
   logic ref_d;
   logic ref_rise;
   logic [23:0] pll_control_word;
   logic [23:0] feedback_divider_word;
   logic [23:0] reference_divider_word;
   logic pump_gain_select;
   logic control_seen;
   slb_power_t pstate;
   logic [1:0] edge_cnt;
   logic [2:0] band_cnt;
   logic band_pending;
   logic ce_low;
   logic wr_ctl;
   logic wr_fb;
   logic wr_ref;
   logic data_meta;
   logic serial_data_sync;
   slb_serial_if sif ();

   // Two-flop synchronisers; the first rank feeds only the second.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         meta <= 5'h00;
         sync <= 5'h00;
      end else begin
         meta <= {loop_locked, ref_div_out, chip_enable, load_strobe,
                  serial_clk};
         sync <= meta;
      end
   end

   slb_shifter u_shift (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .sclk_sync(sync[0]),
      .sdata_sync(serial_data_sync),
      .strobe_sync(sync[1]),
      .sif(sif)
   );

   // Data needs the same two-flop delay as the serial clock.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         data_meta <= 1'b0;
         serial_data_sync <= 1'b0;
      end else begin
         data_meta <= serial_data;
         serial_data_sync <= data_meta;
      end
   end

   assign ce_low = !sync[2];
   assign ref_rise = sync[3] && !ref_d;
   assign wr_ctl = sif.word_valid && sif.word[1:0] == SEL_CONTROL;
   assign wr_fb = sif.word_valid && sif.word[1:0] == SEL_FEEDBACK;
   assign wr_ref = sif.word_valid && sif.word[1:0] == SEL_REFERENCE;

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         ref_d <= 1'b0;
      end else begin
         ref_d <= sync[3];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         pll_control_word <= WORD_RESET;
         feedback_divider_word <= WORD_RESET;
         reference_divider_word <= WORD_RESET;
      end else begin
         if (wr_ctl) begin
            pll_control_word <= sif.word;
         end
         if (wr_fb) begin
            feedback_divider_word <= sif.word;
         end
         if (wr_ref) begin
            reference_divider_word <= sif.word;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         pump_gain_select <= 1'b0;
      end else if (wr_ctl) begin
         pump_gain_select <= sif.word[CT_GAIN];
      end else if (wr_fb) begin
         pump_gain_select <= sif.word[FB_GAIN];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         control_seen <= 1'b0;
         bias_settle_start <= 1'b0;
      end else begin
         bias_settle_start <= wr_ctl && !control_seen;
         if (wr_ctl) begin
            control_seen <= 1'b1;
         end
      end
   end

   // Power state. Chip-enable low overrides everything.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         pstate <= SLB_OFF;
         edge_cnt <= 2'h0;
      end else if (ce_low) begin
         pstate <= SLB_OFF;
      end else if (wr_ctl) begin
         edge_cnt <= 2'h0;
         if (!sif.word[CT_PD_REQ]) begin
            pstate <= SLB_ON;
         end else if (!sif.word[CT_PD_SYNC]) begin
            pstate <= SLB_OFF;
         end else begin
            pstate <= SLB_PD_WAIT;
         end
      end else begin
         case (pstate)
            SLB_OFF: begin
               // Hardware power-up resumes the programmed state.
               if (control_seen && !pll_control_word[CT_PD_REQ]) begin
                  pstate <= SLB_ON;
               end
            end
            SLB_ON: begin
            end
            SLB_PD_WAIT: begin
               if (ref_rise) begin
                  if (edge_cnt == 2'(SYNC_PD_EDGES - 1)) begin
                     pstate <= SLB_OFF;
                  end
                  edge_cnt <= edge_cnt + 2'h1;
               end
            end
            default: pstate <= SLB_OFF;
         endcase
      end
   end

   assign powered = pstate != SLB_OFF;

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         band_pending <= 1'b0;
         band_cnt <= 3'h0;
      end else begin
         if (wr_fb) begin
            band_pending <= 1'b1;
            band_cnt <= 3'h0;
         end else if (band_pending && powered && ref_rise) begin
            if (band_cnt == 3'(BAND_CYCLES - 1)) begin
               band_pending <= 1'b0;
            end
            band_cnt <= band_cnt + 3'h1;
         end
      end
   end

   assign band_select_busy = band_pending && powered;

   assign counters_load = !powered;
   assign lock_detect_reset = !powered;
   assign ref_buffer_enable = powered;
   assign pump_tristate_out = !powered || pll_control_word[CT_TRISTATE];
   assign rf_output_enable = powered &&
      (!pll_control_word[CT_MUTE] || sync[4]);

   assign pump_current = pump_gain_select ?
      pll_control_word[CT_CUR2_HI:CT_CUR2_LO] :
      pll_control_word[CT_CUR1_HI:CT_CUR1_LO];

   assign prescale_sel = pll_control_word[CT_PRESCALE_HI:CT_PRESCALE_LO];
   assign output_drive = pll_control_word[CT_DRIVE_HI:CT_DRIVE_LO];
   assign core_bias_level = pll_control_word[CT_BIAS_HI:CT_BIAS_LO];
   assign monitor_select = pll_control_word[CT_MON_HI:CT_MON_LO];
   assign detector_polarity = pll_control_word[CT_POLARITY];
   assign counter_clear = pll_control_word[CT_CLEAR];
   assign feedback_halve_select = feedback_divider_word[FB_HALVE_SEL];
   assign output_halve = feedback_divider_word[FB_HALVE];
   assign main_count = feedback_divider_word[FB_MAIN_HI:FB_MAIN_LO];
   assign swallow_count = feedback_divider_word[FB_SWALLOW_HI:FB_SWALLOW_LO];
   assign band_clock_div = reference_divider_word[RF_BAND_HI:RF_BAND_LO];
   assign factory_test_bit = reference_divider_word[RF_TEST];
   assign lock_precision = reference_divider_word[RF_PRECISION];
   assign antibacklash_width = reference_divider_word[RF_ABL_HI:RF_ABL_LO];
   assign ref_count = reference_divider_word[RF_COUNT_HI:RF_COUNT_LO];
endmodule

/* tb/slb_latch_bank_assertions.sv */
// Purpose: Port-level checks on the synthesizer latch bank.
// Assumes: One clk_sys domain, sys_rst synchronous and active high.
// Notes: Of the divider counts, only main_count and ref_count are checked, for stability between strobes.
module slb_latch_bank_checker
(
   input logic clk_sys,
   input logic sys_rst,
   input logic load_strobe,
   input logic chip_enable,
   input logic powered,
   input logic bias_settle_start,
   input logic counters_load,
   input logic pump_tristate_out,
   input logic lock_detect_reset,
   input logic rf_output_enable,
   input logic ref_buffer_enable,
   input logic band_select_busy,
   input logic [12:0] main_count,
   input logic [13:0] ref_count
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   property p_counters_load;
      counters_load == !powered;
   endproperty
   a_counters_load: assert property (p_counters_load)
      else $error("counters_load differs from power state");
   property p_ref_buf;
      ref_buffer_enable == powered;
   endproperty
   a_ref_buf: assert property (p_ref_buf)
      else $error("reference buffer differs from power state");
   property p_pd_outputs;
      !powered |-> pump_tristate_out && lock_detect_reset;
   endproperty
   a_pd_outputs: assert property (p_pd_outputs)
      else $error("pump or lock detect active while powered down");
   property p_rf_power;
      rf_output_enable |-> powered && ref_buffer_enable;
   endproperty
   a_rf_power: assert property (p_rf_power)
      else $error("RF output enabled without power");
   property p_ce_off;
      !chip_enable [*6] |-> !powered;
   endproperty
   a_ce_off: assert property (p_ce_off)
      else $error("chip enable low did not disable");
   property p_bias_pulse;
      bias_settle_start |-> powered ##1 !bias_settle_start;
   endproperty
   a_bias_pulse: assert property (p_bias_pulse)
      else $error("bias settle pulse malformed");
   property p_ref_stable;
      !load_strobe [*8] |-> $stable(ref_count);
   endproperty
   a_ref_stable: assert property (p_ref_stable)
      else $error("ref_count changed without a load");
   property p_main_stable;
      !load_strobe [*8] |-> $stable(main_count);
   endproperty
   a_main_stable: assert property (p_main_stable)
      else $error("main_count changed without a load");
   c_power_up: cover property ($rose(powered));
   c_band_done: cover property ($fell(band_select_busy));
   c_ce_off: cover property ($fell(powered) && !chip_enable);
endmodule
bind slb_latch_bank slb_latch_bank_checker u_slb_latch_bank_checker (
   .clk_sys(clk_sys),
   .sys_rst(sys_rst),
   .load_strobe(load_strobe),
   .chip_enable(chip_enable),
   .powered(powered),
   .bias_settle_start(bias_settle_start),
   .counters_load(counters_load),
   .pump_tristate_out(pump_tristate_out),
   .lock_detect_reset(lock_detect_reset),
   .rf_output_enable(rf_output_enable),
   .ref_buffer_enable(ref_buffer_enable),
   .band_select_busy(band_select_busy),
   .main_count(main_count),
   .ref_count(ref_count)
);

/* tb/slb_host_model.sv */
// Purpose: Host side of the three-wire link to the latch bank.
// Assumes: Driven on falling clk_sys edges, eight cycles per serial bit.
// Notes: SETTLE_CYCLES stands in for the long power-up interval.
module slb_host_model
   import slb_pkg::*;
#(
   parameter int SETTLE_CYCLES = 200
)
(
   input wire logic clk_sys,
   output logic serial_clk,
   output logic serial_data,
   output logic load_strobe
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      serial_clk = 1'b0;
      serial_data = 1'b0;
      load_strobe = 1'b0;
   end
   task automatic idle(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   task automatic send_word(input logic [WORD_W-1:0] w);
      idle(1);
      for (int i = WORD_W - 1; i >= 0; i--) begin
         serial_clk <= 1'b0;
         serial_data <= w[i];
         idle(4);
         serial_clk <= 1'b1;
         idle(4);
      end
      serial_clk <= 1'b0;
      idle(2);
      load_strobe <= 1'b1;
      idle(8);
      load_strobe <= 1'b0;
      // Released data is not left looking valid.
      serial_data <= ~serial_data;
      idle(2);
   endtask
   task automatic program_all(input logic [23:0] r, c, n);
      send_word(r);
      send_word(c);
      idle(SETTLE_CYCLES);
      send_word(n);
   endtask
endmodule

/* tb/slb_latch_bank_tb_top.sv */
// Purpose: Self-checking bench for the synthesizer latch bank.
// Assumes: Host model drives the serial pins; bench drives the rest.
// Notes: Latch results are read after each word's strobe has ended.
module slb_latch_bank_tb_top
   import slb_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [23:0] REF_W = {4'h2, 2'h3, 2'h3, 14'h1abc, SEL_REFERENCE};
   localparam logic [23:0] CTL_W =
      {10'h295, 2'h1, 4'h1, 3'h6, 3'h2, SEL_CONTROL};
   localparam logic [23:0] FB_W = {3'h4, 13'h1234, 1'b0, 5'h15, SEL_FEEDBACK};
   logic clk_sys = 1'b0, sys_rst = 1'b1, chip_enable = 1'b1;
   logic ref_div_out = 1'b0, loop_locked = 1'b0;
   logic serial_clk, serial_data, load_strobe, powered, bias_settle_start;
   logic counters_load, pump_tristate_out, lock_detect_reset;
   logic rf_output_enable, ref_buffer_enable, band_select_busy;
   logic detector_polarity, counter_clear, feedback_halve_select;
   logic output_halve, factory_test_bit, lock_precision;
   logic [2:0] pump_current, monitor_select;
   logic [1:0] prescale_sel, output_drive, core_bias_level;
   logic [1:0] band_clock_div, antibacklash_width;
   logic [12:0] main_count;
   logic [4:0] swallow_count;
   logic [13:0] ref_count;
   int n_mismatch = 0, checked = 0, n_bias = 0;
   always #2.5 clk_sys = ~clk_sys;
   slb_host_model #(.SETTLE_CYCLES(200)) u_slb_host_model (
      .clk_sys(clk_sys),
      .serial_clk(serial_clk),
      .serial_data(serial_data),
      .load_strobe(load_strobe)
   );
   slb_latch_bank u_slb_latch_bank (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .serial_clk(serial_clk),
      .serial_data(serial_data),
      .load_strobe(load_strobe),
      .chip_enable(chip_enable),
      .ref_div_out(ref_div_out),
      .loop_locked(loop_locked),
      .powered(powered),
      .bias_settle_start(bias_settle_start),
      .counters_load(counters_load),
      .pump_tristate_out(pump_tristate_out),
      .lock_detect_reset(lock_detect_reset),
      .rf_output_enable(rf_output_enable),
      .ref_buffer_enable(ref_buffer_enable),
      .band_select_busy(band_select_busy),
      .pump_current(pump_current),
      .prescale_sel(prescale_sel),
      .output_drive(output_drive),
      .core_bias_level(core_bias_level),
      .monitor_select(monitor_select),
      .detector_polarity(detector_polarity),
      .counter_clear(counter_clear),
      .feedback_halve_select(feedback_halve_select),
      .output_halve(output_halve),
      .main_count(main_count),
      .swallow_count(swallow_count),
      .band_clock_div(band_clock_div),
      .factory_test_bit(factory_test_bit),
      .lock_precision(lock_precision),
      .antibacklash_width(antibacklash_width),
      .ref_count(ref_count)
   );
   always @(posedge clk_sys) if (bias_settle_start === 1'b1) n_bias++;
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      if (n_mismatch == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   task automatic ref_pulses(input int n);
      repeat (n) begin
         ref_div_out = 1'b1;
         cyc(4);
         ref_div_out = 1'b0;
         cyc(4);
      end
   endtask
   function automatic logic [23:0] ctl(input logic sy, rq, mu, ga);
      logic [23:0] w;
      w = CTL_W;
      w[CT_PD_SYNC] = sy;
      w[CT_PD_REQ] = rq;
      w[CT_MUTE] = mu;
      w[CT_GAIN] = ga;
      return w;
   endfunction
   initial begin
      cyc(20000);
      n_mismatch++;
      give_verdict();
   end
   initial begin
      cyc(12);
      sys_rst = 1'b0;
      cyc(2);
      check(powered, 1'b0);
      check(pump_tristate_out, 1'b1);
      u_slb_host_model.program_all(REF_W, ctl(0, 0, 0, 1), FB_W);
      check(ref_count, 14'h1abc);
      check({band_clock_div, factory_test_bit, lock_precision}, 4'hb);
      check(antibacklash_width, 2'h3);
      check(powered, 1'b1);
      check(24'(n_bias), 24'h000001);
      check({prescale_sel, output_drive, core_bias_level}, 6'h26);
      check({monitor_select, detector_polarity, counter_clear}, 5'h1a);
      check({main_count, swallow_count}, {13'h1234, 5'h15});
      check({feedback_halve_select, output_halve}, 2'h2);
      check(pump_current, 3'h5);
      check(band_select_busy, 1'b1);
      ref_pulses(3);
      check(band_select_busy, 1'b1);
      ref_pulses(1);
      check(band_select_busy, 1'b1);
      ref_pulses(1);
      check(band_select_busy, 1'b0);
      u_slb_host_model.send_word({FB_W[23:2] ^ 22'h3fc0, SEL_TEST});
      check(main_count, 13'h1234);
      u_slb_host_model.send_word(ctl(0, 0, 1, 1));
      check({pump_current, rf_output_enable}, 4'h4);
      loop_locked = 1'b1;
      cyc(6);
      check(rf_output_enable, 1'b1);
      u_slb_host_model.send_word(ctl(0, 1, 1, 1));
      check({powered, counters_load, lock_detect_reset}, 3'h3);
      check({pump_tristate_out, rf_output_enable, ref_buffer_enable},
         3'h4);
      u_slb_host_model.send_word({REF_W[23:16], 14'h0123, SEL_REFERENCE});
      check(ref_count, 14'h0123);
      u_slb_host_model.send_word(ctl(0, 0, 0, 1));
      check({powered, band_select_busy}, 2'h2);
      u_slb_host_model.send_word(ctl(1, 1, 0, 1));
      ref_pulses(1);
      check(powered, 1'b1);
      ref_pulses(1);
      cyc(2);
      check(powered, 1'b0);
      u_slb_host_model.send_word(ctl(0, 0, 0, 1));
      check(powered, 1'b1);
      chip_enable = 1'b0;
      cyc(6);
      check(powered, 1'b0);
      chip_enable = 1'b1;
      cyc(6);
      check(powered, 1'b1);
      give_verdict();
   end
endmodule
